// ### common/dpc_pkg.sv
package dpc_pkg;
    // Channel bank
    localparam int NCH = 6;
    localparam int NPAIR = 3;
    localparam int SEL_W = 3;
    localparam int CNT_W = 32;
    localparam int GATE_W = 16;
    localparam int ADDR_W = 8;
    localparam int MS_W = 16;
    localparam int SEC_W = 10;
    localparam int FCNT_W = 6;
    // Timing: clock period, filter timebase in ns, ms per second
    localparam int CLK_NS = 50;
    localparam int MS_NS = 1000000;
    localparam int MS_CYC = (MS_NS + CLK_NS - 1) / CLK_NS;
    localparam int MS_PER_S = 1000;
    // Filter select codes: 0 = bypass, n = 2**(n-1) ms, top code 32 ms
    localparam logic [SEL_W-1:0] SEL_BYPASS = 3'h0;
    localparam logic [SEL_W-1:0] SEL_MAX = 3'h6;
    // Register byte addresses
    localparam logic [ADDR_W-1:0] A_FILT = 8'h00;
    localparam logic [ADDR_W-1:0] A_GATE = 8'h04;
    localparam logic [ADDR_W-1:0] A_QUAD = 8'h08;
    localparam logic [ADDR_W-1:0] A_RETAIN = 8'h0c;
    localparam logic [ADDR_W-1:0] A_STAT = 8'h10;
    localparam logic [ADDR_W-1:0] A_CNT = 8'h20;
    localparam logic [ADDR_W-1:0] A_RATE = 8'h40;
    localparam logic [ADDR_W-1:0] A_SPAN = 8'h18;
    // Reset values
    localparam logic [SEL_W*NCH-1:0] FILT_RST = 18'h00000;
    localparam logic [GATE_W-1:0] GATE_RST = 16'h0001;
    localparam logic [NPAIR-1:0] QUAD_RST = 3'h0;
    localparam logic [NCH-1:0] RETAIN_RST = 6'h00;
    localparam logic [CNT_W-1:0] CNT_ZERO = 32'h00000000;
    localparam logic [CNT_W-1:0] CNT_ONE = 32'h00000001;
    localparam logic signed [1:0] DIR_UP = 2'sh1;
    localparam logic signed [1:0] DIR_DN = -2'sh1;
    localparam logic signed [1:0] DIR_STILL = 2'sh0;
endpackage : dpc_pkg

// ### src/dpc_filt.sv
`timescale 1ns/1ps
module dpc_filt
    import dpc_pkg::*;
(
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // Timebase and setting
    input wire logic tick,
    input wire logic [SEL_W-1:0] sel,
    // Signal
    input wire logic raw,
    output logic filt
);
    logic [FCNT_W-1:0] cnt_r;
    logic [FCNT_W-1:0] lim;
    logic [SEL_W-1:0] sel_c;

    always_comb begin
        sel_c = (sel > SEL_MAX) ? SEL_MAX : sel;
        lim = FCNT_W'(1) << (sel_c - 3'h1);
    end

    // hold then switch
    // Switch on the tick after lim full ticks, so the hold is never shorter than lim ms
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            filt <= 1'b0;
            cnt_r <= '0;
        end else if (sel == SEL_BYPASS) begin
            filt <= raw;
            cnt_r <= '0;
        end else if (raw == filt) begin
            cnt_r <= '0;
        end else if (tick) begin
            if (cnt_r >= lim) begin
                filt <= raw;
                cnt_r <= '0;
            end else begin
                cnt_r <= cnt_r + FCNT_W'(1);
            end
        end
    end

    chk_filt_bypass:
    assert property (@(posedge mclk) disable iff (!rst_n)
        (sel == SEL_BYPASS) |=> (filt == $past(raw)))
    else $error("filter bypass did not follow input");

    chk_filt_tick_only:
    assert property (@(posedge mclk) disable iff (!rst_n)
        ($changed(filt) && $past(sel) != SEL_BYPASS) |-> $past(tick) && $past(raw) == filt)
    else $error("filter changed without a full hold");
endmodule : dpc_filt

// ### src/dpc_top.sv
// The register addresses and the Avalon-MM interface to the registers were left to the implementer.
`timescale 1ns/1ps
// Notes on behaviour
// - Input low or closed reads ON
// - Six independent discrete input channels
// - Each channel owns its pulse counter
// - Filter selectable 0,1,2,4,8,16,32 ms
// - Count increments on every ON transition
// - Counter sees only the filtered input
// - 32-bit unsigned totalizer wraps to zero
// - Writing zero clears totalizer anytime, except on channels of a quadrature pair
// - Totalizer may be retentive, reloadable
// - Rate from pulses over whole-second gate
// - Rate refreshed once per gate interval
// - Quadrature pair: signed 32-bit position
module dpc_top
    import dpc_pkg::*;
#(
    parameter int MS_CYCLES = MS_CYC
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // Field inputs, low level means ON
    input wire logic [NCH-1:0] din_n,
    // Avalon-MM slave
    input wire logic [ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest
);
    logic [MS_W-1:0] ms_cnt_r;
    logic ms_tick_r;
    logic [SEC_W-1:0] s_cnt_r;
    logic sec_tick_r;
    logic [GATE_W-1:0] g_cnt_r;
    logic [GATE_W-1:0] gate_lim;
    logic gate_end_r;
    logic [SEL_W*NCH-1:0] filt_sel_r;
    logic [GATE_W-1:0] gate_r;
    logic [NPAIR-1:0] quad_en_r;
    logic [NCH-1:0] retain_r;
    logic wait_r;
    logic [31:0] rdata_r;
    logic [31:0] rdata_nxt;
    logic wr_acc;
    logic [ADDR_W-1:0] cnt_off;
    logic [ADDR_W-1:0] rate_off;
    logic cnt_hit;
    logic rate_hit;
    logic [2:0] cnt_idx;
    logic [2:0] rate_idx;
    logic [31:0] wr_word;
    logic [NCH-1:0] raw_on;
    logic [NCH-1:0] filt;
    logic [NCH-1:0] filt_q_r;
    logic [NCH-1:0] on_edge;
    logic [NCH-1:0] quad_ch;
    logic [CNT_W-1:0] tot_r [NCH];
    logic [CNT_W-1:0] acc_r [NCH];
    logic [CNT_W-1:0] rate_r [NCH];
    logic signed [CNT_W-1:0] pos_r [NPAIR];
    logic signed [1:0] dir_r [NPAIR];
    logic [NPAIR-1:0] moved_r;
    logic [NPAIR-1:0] step_up;
    logic [NPAIR-1:0] step_dn;

    function automatic logic [31:0] be_merge(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0] be);
        logic [31:0] m;
        m = old_v;
        for (int b = 0; b < 4; b++) begin
            if (be[b]) begin
                m[8*b +: 8] = new_v[8*b +: 8];
            end
        end
        return m;
    endfunction : be_merge

    // Millisecond, second and gate timebase
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            ms_cnt_r <= '0;
            ms_tick_r <= 1'b0;
        end else if (ms_cnt_r == MS_W'(MS_CYCLES - 1)) begin
            ms_cnt_r <= '0;
            ms_tick_r <= 1'b1;
        end else begin
            ms_cnt_r <= ms_cnt_r + MS_W'(1);
            ms_tick_r <= 1'b0;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            s_cnt_r <= '0;
            sec_tick_r <= 1'b0;
        end else begin
            sec_tick_r <= 1'b0;
            if (ms_tick_r) begin
                if (s_cnt_r == SEC_W'(MS_PER_S - 1)) begin
                    s_cnt_r <= '0;
                    sec_tick_r <= 1'b1;
                end else begin
                    s_cnt_r <= s_cnt_r + SEC_W'(1);
                end
            end
        end
    end

    // A zero gate setting runs as one second
    assign gate_lim = (gate_r == '0) ? GATE_RST : gate_r;

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            g_cnt_r <= '0;
            gate_end_r <= 1'b0;
        end else begin
            gate_end_r <= 1'b0;
            if (sec_tick_r) begin
                if (g_cnt_r >= gate_lim - GATE_W'(1)) begin
                    g_cnt_r <= '0;
                    gate_end_r <= 1'b1;
                end else begin
                    g_cnt_r <= g_cnt_r + GATE_W'(1);
                end
            end
        end
    end

    // Bus slave: one wait state, a write is taken at the edge where waitrequest is low, read data are latched one edge earlier
    assign wr_acc = avs_write && !wait_r;
    assign cnt_off = avs_address - A_CNT;
    assign rate_off = avs_address - A_RATE;
    assign cnt_hit = (avs_address >= A_CNT) && (cnt_off < A_SPAN);
    assign rate_hit = (avs_address >= A_RATE) && (rate_off < A_SPAN);
    assign cnt_idx = cnt_off[4:2];
    assign rate_idx = rate_off[4:2];
    // Byte lanes merge into the addressed register's current value
    assign wr_word = be_merge(rdata_nxt, avs_writedata, avs_byteenable);

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            wait_r <= 1'b1;
        end else begin
            wait_r <= !((avs_read || avs_write) && wait_r);
        end
    end

    always_comb begin
        rdata_nxt = '0;
        if (cnt_hit) begin
            rdata_nxt = tot_r[cnt_idx];
            if (quad_ch[cnt_idx] && !cnt_idx[0]) begin
                rdata_nxt = pos_r[cnt_idx[2:1]];
            end else if (quad_ch[cnt_idx]) begin
                rdata_nxt = 32'(signed'(dir_r[cnt_idx[2:1]]));
            end
        end else if (rate_hit) begin
            rdata_nxt = rate_r[rate_idx];
        end else begin
            case (avs_address)
                A_FILT: rdata_nxt = 32'(filt_sel_r);
                A_GATE: rdata_nxt = 32'(gate_r);
                A_QUAD: rdata_nxt = 32'(quad_en_r);
                A_RETAIN: rdata_nxt = 32'(retain_r);
                A_STAT: rdata_nxt = 32'(filt);
                default: rdata_nxt = '0;
            endcase
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_r <= '0;
        end else if (avs_read && wait_r) begin
            rdata_r <= rdata_nxt;
        end
    end
    assign avs_waitrequest = wait_r;
    assign avs_readdata = rdata_r;
    // Configuration registers
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            filt_sel_r <= FILT_RST;
            gate_r <= GATE_RST;
            quad_en_r <= QUAD_RST;
            retain_r <= RETAIN_RST;
        end else if (wr_acc) begin
            case (avs_address)
                A_FILT: filt_sel_r <= wr_word[SEL_W*NCH-1:0];
                A_GATE: gate_r <= wr_word[GATE_W-1:0];
                A_QUAD: quad_en_r <= wr_word[NPAIR-1:0];
                A_RETAIN: retain_r <= wr_word[NCH-1:0];
                default: ;
            endcase
        end
    end

    assign raw_on = ~din_n;

    generate
        for (genvar i = 0; i < NCH; i++) begin : g_ch
            dpc_filt u_filt (
                .mclk(mclk),
                .rst_n(rst_n),
                .tick(ms_tick_r),
                .sel(filt_sel_r[SEL_W*i +: SEL_W]),
                .raw(raw_on[i]),
                .filt(filt[i])
            );
            assign quad_ch[i] = quad_en_r[i / 2];
        end
    endgenerate

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            filt_q_r <= '0;
        end else begin
            filt_q_r <= filt;
        end
    end

    assign on_edge = filt & ~filt_q_r;

    // totalizers, a count in the clearing cycle survives
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < NCH; i++) begin
                tot_r[i] <= CNT_ZERO;
            end
        end else begin
            for (int i = 0; i < NCH; i++) begin
                if (wr_acc && cnt_hit && cnt_idx == 3'(i) && !quad_ch[i]) begin
                    if (wr_word == CNT_ZERO) begin
                        tot_r[i] <= on_edge[i] ? CNT_ONE : CNT_ZERO;
                    end else if (retain_r[i]) begin
                        tot_r[i] <= wr_word + CNT_W'(on_edge[i]);
                    end else begin
                        tot_r[i] <= tot_r[i] + CNT_W'(on_edge[i]);
                    end
                end else if (on_edge[i]) begin
                    tot_r[i] <= tot_r[i] + CNT_ONE;
                end
            end
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < NCH; i++) begin
                acc_r[i] <= CNT_ZERO;
                rate_r[i] <= CNT_ZERO;
            end
        end else begin
            for (int i = 0; i < NCH; i++) begin
                if (gate_end_r) begin
                    rate_r[i] <= acc_r[i] + CNT_W'(on_edge[i]);
                    acc_r[i] <= CNT_W'(on_edge[i]);
                end else if (on_edge[i]) begin
                    acc_r[i] <= acc_r[i] + CNT_ONE;
                end
            end
        end
    end

    // phase A on the even input leads for positive travel
    always_comb begin
        for (int p = 0; p < NPAIR; p++) begin
            step_up[p] = quad_en_r[p] && ((filt[2*p] ^ filt_q_r[2*p])
                         ^ (filt[2*p+1] ^ filt_q_r[2*p+1]))
                         && !(filt_q_r[2*p] ^ filt[2*p+1]);
            step_dn[p] = quad_en_r[p] && ((filt[2*p] ^ filt_q_r[2*p])
                         ^ (filt[2*p+1] ^ filt_q_r[2*p+1]))
                         && (filt_q_r[2*p] ^ filt[2*p+1]);
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            for (int p = 0; p < NPAIR; p++) begin
                pos_r[p] <= CNT_ZERO;
                dir_r[p] <= DIR_STILL;
                moved_r[p] <= 1'b0;
            end
        end else begin
            for (int p = 0; p < NPAIR; p++) begin
                if (wr_acc && cnt_hit && cnt_idx == 3'(2*p) && quad_en_r[p]
                    && (wr_word == CNT_ZERO || retain_r[2*p])) begin
                    pos_r[p] <= wr_word + (step_up[p] ? CNT_ONE : CNT_ZERO)
                                - (step_dn[p] ? CNT_ONE : CNT_ZERO);
                end else if (step_up[p]) begin
                    pos_r[p] <= pos_r[p] + CNT_ONE;
                end else if (step_dn[p]) begin
                    pos_r[p] <= pos_r[p] - CNT_ONE;
                end
                // Direction drops to zero after a whole gate with no step
                if (step_up[p]) begin
                    dir_r[p] <= DIR_UP;
                end else if (step_dn[p]) begin
                    dir_r[p] <= DIR_DN;
                end else if (gate_end_r && !moved_r[p]) begin
                    dir_r[p] <= DIR_STILL;
                end
                if (gate_end_r) begin
                    moved_r[p] <= step_up[p] || step_dn[p];
                end else if (step_up[p] || step_dn[p]) begin
                    moved_r[p] <= 1'b1;
                end
            end
        end
    end

    chk_tot_count_edge:
    assert property (@(posedge mclk) disable iff (!rst_n)
        (on_edge[0] && !(wr_acc && cnt_hit)) |=> (tot_r[0] == $past(tot_r[0]) + CNT_ONE))
    else $error("totalizer missed an ON transition");
    chk_tot_wrap:
    assert property (@(posedge mclk) disable iff (!rst_n)
        (tot_r[2] == '1 && on_edge[2] && !(wr_acc && cnt_hit)) |=> (tot_r[2] == CNT_ZERO))
    else $error("totalizer did not wrap to zero");
    chk_tot_clear:
    assert property (@(posedge mclk) disable iff (!rst_n)
        (wr_acc && avs_address == A_CNT && avs_writedata == CNT_ZERO
         && avs_byteenable == 4'hf && !quad_ch[0])
        |=> (tot_r[0] == CNT_W'($past(on_edge[0]))))
    else $error("zero write did not clear totalizer");
    chk_bus_answer:
    assert property (@(posedge mclk) disable iff (!rst_n)
        ((avs_read || avs_write) && avs_waitrequest) |=> !avs_waitrequest ##1 avs_waitrequest)
    else $error("bus answer not after one wait state");
    chk_rate_gate:
    assert property (@(posedge mclk) disable iff (!rst_n)
        gate_end_r |=> (rate_r[1] == $past(acc_r[1]) + CNT_W'($past(on_edge[1]))))
    else $error("rate not latched at gate end");
    chk_rate_hold:
    assert property (@(posedge mclk) disable iff (!rst_n)
        !gate_end_r |=> $stable(rate_r[0]))
    else $error("rate changed inside a gate");
    chk_quad_up:
    assert property (@(posedge mclk) disable iff (!rst_n)
        (step_up[2] && !(wr_acc && cnt_hit)) |=> (pos_r[2] == $past(pos_r[2]) + 1)
        and (dir_r[2] == DIR_UP))
    else $error("forward step not counted");
    chk_quad_dir_idle:
    assert property (@(posedge mclk) disable iff (!rst_n)
        (gate_end_r && !moved_r[2] && !step_up[2] && !step_dn[2]) |=> (dir_r[2] == DIR_STILL))
    else $error("direction not cleared after an idle gate");
    chk_quad_off:
    assert property (@(posedge mclk) disable iff (!rst_n)
        !quad_en_r[0] |=> $stable(pos_r[0]))
    else $error("position moved while decoder disabled");
endmodule : dpc_top

// ### sim/dpc_field.sv
`timescale 1ns/1ps
module dpc_field
    import dpc_pkg::*;
(
    // Clock
    input wire logic mclk,
    // Bench control
    input wire logic rate_on,
    // Field side, low level means ON
    output logic [NCH-1:0] din_n
);
    logic [5:0] ph_cnt;
    logic rate_d;
    logic [1:0] qpos [NPAIR];

    initial begin
        din_n = '1;
        ph_cnt = 6'h00;
        rate_d = 1'b0;
        qpos = '{default: 2'h0};
    end

    // Steady train on channel 1, period 40 cycles, so any whole gate sees an exact count
    always @(posedge mclk) begin
        ph_cnt <= (ph_cnt == 6'h27) ? 6'h00 : ph_cnt + 6'h01;
        rate_d <= rate_on;
        if (rate_on) begin
            din_n[1] <= (ph_cnt >= 6'h14);
        end else if (rate_d) begin
            din_n[1] <= 1'b1;
        end
    end

    task automatic hold(input int ch, input logic on, input int cyc);
        @(posedge mclk);
        din_n[ch] <= ~on;
        repeat (cyc - 1) @(posedge mclk);
    endtask : hold

    task automatic pulse(input int ch, input int lo, input int hi);
        hold(ch, 1'b1, lo);
        hold(ch, 1'b0, hi);
    endtask : pulse

    // One quadrature edge; only one phase changes per step
    task automatic step(input int p, input bit fwd, input int gap);
        logic [1:0] q;
        q = fwd ? qpos[p] + 2'h1 : qpos[p] - 2'h1;
        qpos[p] = q;
        @(posedge mclk);
        din_n[2*p] <= ~(q[1] ^ q[0]);
        din_n[2*p+1] <= ~q[1];
        repeat (gap - 1) @(posedge mclk);
    endtask : step
endmodule : dpc_field

// ### sim/dpc_top_tb_top.sv
`timescale 1ns/1ps
module dpc_top_tb_top
    import dpc_pkg::*;
();
    localparam int MSC = 4;
    localparam int GATE_CYC = MS_PER_S * MSC;
    logic mclk = 1'b0;
    logic rst_n;
    logic rate_on;
    logic [NCH-1:0] din_n;
    logic [ADDR_W-1:0] avs_address;
    logic avs_read;
    logic avs_write;
    logic [31:0] avs_writedata;
    logic [3:0] avs_byteenable;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic [31:0] exp_q [$];
    logic [31:0] seed = 32'hf98a;
    logic [31:0] cnt_exp [NCH];
    int failures = 0;
    int comparisons = 0;

    always #25 mclk = ~mclk;

    dpc_top #(.MS_CYCLES(MSC)) i_dpc_top (.mclk(mclk), .rst_n(rst_n), .din_n(din_n),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));
    dpc_field i_dpc_field (.mclk(mclk), .rate_on(rate_on), .din_n(din_n));

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : rnd

    task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            failures++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check_word

    // Read data are taken only at the edge that sees waitrequest low
    always @(posedge mclk) begin
        if (avs_read === 1'b1 && avs_waitrequest === 1'b0) begin
            check_word(avs_readdata, exp_q.pop_front());
        end
    end

    task automatic bus_op(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge mclk);
        avs_address <= a;
        avs_read <= ~wr;
        avs_write <= wr;
        avs_writedata <= d;
        do begin
            @(posedge mclk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 50);
        if (n >= 50) begin
            check_word({31'h0, avs_waitrequest}, 32'h0);
        end
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask : bus_op

    task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
        bus_op(1'b1, a, d);
    endtask : wr

    task automatic rd(input logic [ADDR_W-1:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        bus_op(1'b0, a, 32'h0);
    endtask : rd

    task automatic report_and_stop();
        $display("comparisons=%0d failures=%0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : report_and_stop

    initial begin
        repeat (80000) @(posedge mclk);
        failures++;
        report_and_stop();
    end

    initial begin
        int n;
        int t;
        int g;
        rst_n = 1'b0;
        rate_on = 1'b0;
        avs_address = 8'h00;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0;
        avs_byteenable = 4'hf;
        repeat (3) @(posedge mclk);
        rst_n <= 1'b1;
        rd(A_FILT, 32'h0);
        rd(A_GATE, 32'h1);
        rd(A_QUAD, 32'h0);
        rd(A_RETAIN, 32'h0);
        rd(A_STAT, 32'h0);
        rd(8'h80, 32'h0);
        $display("test reset_values done");
        // Each channel gets its own random count to expose crosstalk
        for (int i = 0; i < NCH; i++) begin
            cnt_exp[i] = 32'h1 + rnd() % 32'h5;
            repeat (cnt_exp[i]) i_dpc_field.pulse(i, 1, 1);
        end
        for (int i = 0; i < NCH; i++) begin
            rd(8'(A_CNT + 4 * i), cnt_exp[i]);
        end
        i_dpc_field.hold(3, 1'b1, 4);
        rd(A_STAT, 32'h8);
        i_dpc_field.hold(3, 1'b0, 2);
        $display("test bypass_count done");
        wr(8'h28, 32'h5);
        rd(8'h28, cnt_exp[2]);
        wr(8'h28, 32'h0);
        rd(8'h28, 32'h0);
        wr(A_RETAIN, 32'h4);
        rd(A_RETAIN, 32'h4);
        wr(8'h28, 32'hffff_fffe);
        rd(8'h28, 32'hffff_fffe);
        repeat (2) i_dpc_field.pulse(2, 1, 1);
        rd(8'h28, 32'h0);
        $display("test clear_wrap done");
        // A glitch shorter than the time constant must vanish
        for (int c = 1; c <= 6; c++) begin
            t = (1 << (c - 1)) * MSC;
            g = 1 + int'(rnd() % 32'(t - 2));
            wr(A_FILT, 32'(c));
            rd(A_FILT, 32'(c));
            wr(A_CNT, 32'h0);
            i_dpc_field.pulse(0, g, t + 2 * MSC);
            i_dpc_field.pulse(0, t + 2 * MSC, t + 2 * MSC);
            rd(A_CNT, 32'h1);
        end
        wr(A_FILT, 32'h0);
        $display("test filter done");
        rate_on <= 1'b1;
        repeat (2 * GATE_CYC + 100) @(posedge mclk);
        rd(8'h44, 32'h64);
        wr(A_GATE, 32'h2);
        rd(A_GATE, 32'h2);
        repeat (6 * GATE_CYC) @(posedge mclk);
        rd(8'h44, 32'hc8);
        rate_on <= 1'b0;
        repeat (4 * GATE_CYC + 100) @(posedge mclk);
        rd(8'h44, 32'h0);
        $display("test rate done");
        wr(A_QUAD, 32'h4);
        rd(A_QUAD, 32'h4);
        n = 4 + int'(rnd() % 32'h8);
        repeat (n) i_dpc_field.step(2, 1'b1, 2 + int'(rnd() % 32'h4));
        rd(8'h30, 32'(n));
        rd(8'h34, 32'h1);
        repeat (n + 3) i_dpc_field.step(2, 1'b0, 2 + int'(rnd() % 32'h4));
        rd(8'h30, 32'hffff_fffd);
        rd(8'h34, 32'hffff_ffff);
        repeat (4 * GATE_CYC + 100) @(posedge mclk);
        rd(8'h34, 32'h0);
        rd(8'h30, 32'hffff_fffd);
        $display("test quadrature done");
        report_and_stop();
    end
endmodule : dpc_top_tb_top
